// >>> lfc_store.sv
// Lock bit, fuse, signature and calibration store with register port
`timescale 1ns/1ps
module lfc_store #(
    parameter logic [7:0] SIG0     = 8'ha5, // Arbitrary identity value
    parameter logic [7:0] SIG1     = 8'h3c, // Arbitrary identity value
    parameter logic [7:0] SIG2     = 8'h66, // Arbitrary identity value
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     nrst_i,
    input  wire logic               [3:0] addr_i,
    input  wire logic               [7:0] wdata_i,
    input  wire logic                     we_i,
    input  wire logic                     re_i,
    input  wire logic                     prog_mode_i,
    input  wire logic                     hv_mode_i,
    output logic                    [7:0] rdata_o,
    output lfc_pkg::lfc_prot_s            prot_o,
    output logic                    [1:0] lock_mode_o,
    output logic                          debug_flash_read_o,
    output logic                          flash_erase_o,
    output logic                          eeprom_erase_o,
    output lfc_pkg::lfc_fuse_s            fuse_live_o,
    output logic                          int_rc_select_o,
    output logic                    [7:0] osc_trim_o
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic       rst_n;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    lfc_pkg::lfc_mode_e mode;
    lfc_pkg::lfc_mode_e next_mode;
    lfc_pkg::lfc_fuse_s fuse_store;
    lfc_pkg::lfc_fuse_s next_fuse_store;
    lfc_pkg::lfc_fuse_s fuse_live;
    lfc_pkg::lfc_fuse_s next_fuse_live;
    logic         [7:0] lock_store;
    logic         [7:0] next_lock_store;
    logic               booted;
    logic               next_booted;
    logic         [7:0] next_rdata;
    logic               next_flash_erase;
    logic               next_eeprom_erase;
    logic         [7:0] next_trim;
    logic               in_prog;
    logic               erase_cmd;
    logic               fuse_wr_ok;
    logic         [7:0] high_mask;
    lfc_pkg::lfc_prot_s prot;
    logic         [1:0] lock_mode;

    lfc_lock_decode u_decode (
        .lock_byte_i  (lock_store),
        .debug_fuse_i (fuse_live.high[lfc_pkg::HIGH_DEBUG_BIT]),
        .prot_o       (prot),
        .lock_mode_o  (lock_mode)
    );

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    always_comb begin
        in_prog    = (mode == lfc_pkg::LFC_PROG);
        next_mode  = prog_mode_i ? lfc_pkg::LFC_PROG : lfc_pkg::LFC_NORMAL;
        erase_cmd  = in_prog && we_i && (addr_i == lfc_pkg::OFS_CTRL)
                     && wdata_i[lfc_pkg::CTRL_ERASE_BIT];
        fuse_wr_ok = in_prog && we_i && prot.fuse_ok;
        // Serial path cannot touch the serial download fuse
        high_mask  = hv_mode_i ? 8'hff : ~lfc_pkg::SERIAL_MASK;
        next_lock_store   = lock_store;
        next_fuse_store   = fuse_store;
        next_fuse_live    = fuse_live;
        next_booted       = 1'b1;
        next_flash_erase  = 1'b0;
        next_eeprom_erase = 1'b0;
        next_trim         = osc_trim_o;

        if (in_prog && we_i && (addr_i == lfc_pkg::OFS_LOCK)) begin
            // Writes only program bits; unused bits stay one
            next_lock_store = lock_store & (wdata_i | ~lfc_pkg::LOCK_USED);
        end
        if (erase_cmd) begin
            next_lock_store  = lfc_pkg::LOCK_RST;
            next_flash_erase = 1'b1;
            // Preserve fuse acts from the stored copy, not the latch
            next_eeprom_erase = fuse_store.high[lfc_pkg::HIGH_EE_KEEP_BIT];
        end
        if (fuse_wr_ok) begin
            unique case (addr_i)
                lfc_pkg::OFS_EXT: begin
                    next_fuse_store.ext = wdata_i | ~lfc_pkg::EXT_USED;
                end
                lfc_pkg::OFS_HIGH: begin
                    next_fuse_store.high = (wdata_i & high_mask)
                                         | (fuse_store.high & ~high_mask);
                end
                lfc_pkg::OFS_LOW: begin
                    next_fuse_store.low = wdata_i;
                end
                default: begin
                    next_fuse_store = fuse_store;
                end
            endcase
        end

        // Latch at power-up, on entry and on exit of programming
        if (!booted || (prog_mode_i != in_prog)) begin
            next_fuse_live = fuse_store;
        end

        if (we_i && (addr_i == lfc_pkg::OFS_TRIM)) begin
            next_trim = wdata_i;
        end
        if (!rst_n) begin
            next_trim = CAL_BYTE;
        end

        next_rdata = 8'h00;
        if (re_i) begin
            unique case (addr_i)
                lfc_pkg::OFS_LOCK: next_rdata = lock_store;
                lfc_pkg::OFS_EXT:  next_rdata = fuse_store.ext;
                lfc_pkg::OFS_HIGH: next_rdata = fuse_store.high;
                lfc_pkg::OFS_LOW:  next_rdata = fuse_store.low;
                lfc_pkg::OFS_SIG0: next_rdata = SIG0;
                lfc_pkg::OFS_SIG1: next_rdata = SIG1;
                lfc_pkg::OFS_SIG2: next_rdata = SIG2;
                lfc_pkg::OFS_CAL:  next_rdata = CAL_BYTE;
                lfc_pkg::OFS_CTRL: next_rdata = {6'h00, hv_mode_i, in_prog};
                lfc_pkg::OFS_STAT: next_rdata = {2'h0, lock_mode, prot};
                lfc_pkg::OFS_TRIM: next_rdata = osc_trim_o;
                default:           next_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Stores stand in for nonvolatile cells; reset brings erased lock bits and default fuse values
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode           <= lfc_pkg::LFC_NORMAL;
            lock_store     <= lfc_pkg::LOCK_RST;
            fuse_store     <= {lfc_pkg::EXT_RST, lfc_pkg::HIGH_RST, lfc_pkg::LOW_RST};
            fuse_live      <= {lfc_pkg::EXT_RST, lfc_pkg::HIGH_RST, lfc_pkg::LOW_RST};
            booted         <= 1'b0;
            rdata_o        <= 8'h00;
            flash_erase_o  <= 1'b0;
            eeprom_erase_o <= 1'b0;
        end else begin
            mode           <= next_mode;
            lock_store     <= next_lock_store;
            fuse_store     <= next_fuse_store;
            fuse_live      <= next_fuse_live;
            booted         <= next_booted;
            rdata_o        <= next_rdata;
            flash_erase_o  <= next_flash_erase;
            eeprom_erase_o <= next_eeprom_erase;
        end
    end

    // Trim loads while reset is held, so it needs no asynchronous reset
    always_ff @(posedge ref_clk_i) begin
        osc_trim_o <= next_trim;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prot_o             = prot;
    assign lock_mode_o        = lock_mode;
    assign fuse_live_o        = fuse_live;
    assign debug_flash_read_o = !fuse_live.high[lfc_pkg::HIGH_DEBUG_BIT];
    assign int_rc_select_o    = fuse_live.low[lfc_pkg::LOW_CKSEL_MSB:0]
                                == lfc_pkg::CKSEL_INT_RC;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_lock_one_way;
        @(posedge ref_clk_i) disable iff (!rst_n)
        !erase_cmd |=> ((lock_store & ~$past(lock_store)) == 8'h00);
    endproperty
    a_lock_one_way: assert property (p_lock_one_way)
        else $error("lock bit returned to one without erase");

    property p_erase_unlocks;
        @(posedge ref_clk_i) disable iff (!rst_n)
        erase_cmd |=> (lock_store == 8'hff) ##0 flash_erase_o;
    endproperty
    a_erase_unlocks: assert property (p_erase_unlocks)
        else $error("erase did not restore lock bits");

    property p_debug_read;
        @(posedge ref_clk_i) disable iff (!rst_n)
        !fuse_live.high[6] |-> debug_flash_read_o;
    endproperty
    a_debug_read: assert property (p_debug_read)
        else $error("debug flash read blocked with debug fuse programmed");

    property p_mode1_open;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (lock_store[1:0] == 2'b11) |-> (prot.prog_ok && prot.verify_ok
                                        && prot.fuse_ok && lock_mode_o == 2'h1);
    endproperty
    a_mode1_open: assert property (p_mode1_open)
        else $error("protection applied in lock mode 1");

    property p_mode2;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (lock_store[1:0] == 2'b10) |-> (!prot.prog_ok && prot.verify_ok
                                        && !prot.fuse_ok && !prot.debug_ok);
    endproperty
    a_mode2: assert property (p_mode2)
        else $error("lock mode 2 decode wrong");

    property p_mode3;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (lock_store[1:0] == 2'b00) |-> (!prot.prog_ok && !prot.verify_ok
                                        && !prot.fuse_ok && !prot.debug_ok);
    endproperty
    a_mode3: assert property (p_mode3)
        else $error("lock mode 3 decode wrong");

    property p_fuse_frozen;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (!lock_store[0] || mode != lfc_pkg::LFC_PROG) |=> $stable(fuse_store);
    endproperty
    a_fuse_frozen: assert property (p_fuse_frozen)
        else $error("fuse changed while frozen");

    property p_erase_eeprom;
        @(posedge ref_clk_i) disable iff (!rst_n)
        erase_cmd |=> (eeprom_erase_o == $past(fuse_store.high[3]))
                      && $stable(fuse_store);
    endproperty
    a_erase_eeprom: assert property (p_erase_eeprom)
        else $error("eeprom erase or fuse hold wrong on chip erase");

    property p_serial_guard;
        @(posedge ref_clk_i) disable iff (!rst_n)
        !hv_mode_i |=> (fuse_store.high[5] == $past(fuse_store.high[5]));
    endproperty
    a_serial_guard: assert property (p_serial_guard)
        else $error("serial download fuse changed over serial path");

    property p_live_held;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (mode == lfc_pkg::LFC_PROG && prog_mode_i) |=> $stable(fuse_live);
    endproperty
    a_live_held: assert property (p_live_held)
        else $error("active fuses changed inside programming mode");

    property p_sig_read;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (re_i && addr_i == lfc_pkg::OFS_SIG1) |=> (rdata_o == SIG1);
    endproperty
    a_sig_read: assert property (p_sig_read)
        else $error("signature read wrong");

    property p_trim_reset;
        @(posedge ref_clk_i) !rst_n |=> (osc_trim_o == CAL_BYTE);
    endproperty
    a_trim_reset: assert property (p_trim_reset)
        else $error("trim not loaded from calibration during reset");

    property p_unused_one;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (re_i && addr_i == lfc_pkg::OFS_EXT) |=> (rdata_o[7:1] == 7'h7f);
    endproperty
    a_unused_one: assert property (p_unused_one)
        else $error("unused extended fuse bits not one");

    property p_boot_capture;
        @(posedge ref_clk_i) disable iff (!rst_n)
        !booted |=> (fuse_live == $past(fuse_store));
    endproperty
    a_boot_capture: assert property (p_boot_capture)
        else $error("fuses not captured after power-up");

    property p_entry_capture;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (prog_mode_i && mode != lfc_pkg::LFC_PROG) |=> (fuse_live == $past(fuse_store));
    endproperty
    a_entry_capture: assert property (p_entry_capture)
        else $error("fuses not captured on programming entry");

    property p_lock_unused;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (lock_store | lfc_pkg::LOCK_USED) == 8'hff;
    endproperty
    a_lock_unused: assert property (p_lock_unused)
        else $error("unused lock bits not one");

    // Preserve fuse may only veto, never start, an eeprom erase
    property p_eeprom_with_flash;
        @(posedge ref_clk_i) disable iff (!rst_n)
        eeprom_erase_o |-> flash_erase_o;
    endproperty
    a_eeprom_with_flash: assert property (p_eeprom_with_flash)
        else $error("eeprom erase without chip erase");

    c_erase: cover property (@(posedge ref_clk_i) disable iff (!rst_n) erase_cmd);
    c_mode3: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
                             lock_mode_o == 2'h3);
    c_fuse_wr: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
                               fuse_wr_ok && addr_i == lfc_pkg::OFS_HIGH);
    c_mode2: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
                             lock_mode_o == 2'h2);
    c_debug: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
                             prot.debug_ok && !fuse_live.high[lfc_pkg::HIGH_DEBUG_BIT]);

endmodule

// >>> lfc_pkg.sv
// Shared constants and types for the lock and fuse configuration store
package lfc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W   = 4;
    localparam int          DATA_W   = 8;
    localparam logic [3:0]  OFS_LOCK = 4'h0;
    localparam logic [3:0]  OFS_EXT  = 4'h1;
    localparam logic [3:0]  OFS_HIGH = 4'h2;
    localparam logic [3:0]  OFS_LOW  = 4'h3;
    localparam logic [3:0]  OFS_SIG0 = 4'h4;
    localparam logic [3:0]  OFS_SIG1 = 4'h5;
    localparam logic [3:0]  OFS_SIG2 = 4'h6;
    localparam logic [3:0]  OFS_CAL  = 4'h7;
    localparam logic [3:0]  OFS_CTRL = 4'h8;
    localparam logic [3:0]  OFS_STAT = 4'h9;
    localparam logic [3:0]  OFS_TRIM = 4'ha;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LOCK_LOW_BIT      = 0;
    localparam int LOCK_HIGH_BIT     = 1;
    localparam int EXT_SELF_PROG_BIT = 0;
    localparam int HIGH_RST_DIS_BIT  = 7;
    localparam int HIGH_DEBUG_BIT    = 6;
    localparam int HIGH_SERIAL_BIT   = 5;
    localparam int HIGH_WDOG_BIT     = 4;
    localparam int HIGH_EE_KEEP_BIT  = 3;
    localparam int HIGH_BOD_MSB      = 2;
    localparam int LOW_DIV8_BIT      = 7;
    localparam int LOW_CLKOUT_BIT    = 6;
    localparam int LOW_SUT_MSB       = 5;
    localparam int LOW_SUT_LSB       = 4;
    localparam int LOW_CKSEL_MSB     = 3;
    localparam int CTRL_ERASE_BIT    = 0;

    localparam logic [7:0] LOCK_USED   = 8'h03;
    localparam logic [7:0] EXT_USED    = 8'h01;
    localparam logic [7:0] SERIAL_MASK = 8'h20;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] LOCK_RST      = 8'hff;
    localparam logic [7:0] EXT_RST       = 8'hff;
    localparam logic [7:0] HIGH_RST      = 8'hdf;
    localparam logic [7:0] LOW_RST       = 8'h62;
    localparam logic [3:0] CKSEL_INT_RC  = 4'h2;
    localparam logic [1:0] LOCK_MODE_1   = 2'h1;
    localparam logic [1:0] LOCK_MODE_2   = 2'h2;
    localparam logic [1:0] LOCK_MODE_3   = 2'h3;

    typedef struct packed {
        logic [7:0] ext;
        logic [7:0] high;
        logic [7:0] low;
    } lfc_fuse_s;

    typedef struct packed {
        logic prog_ok;
        logic verify_ok;
        logic fuse_ok;
        logic debug_ok;
    } lfc_prot_s;

    typedef enum {LFC_NORMAL, LFC_PROG} lfc_mode_e;

endpackage

// >>> lfc_lock_decode.sv
// Lock bit protection mode decoder
`timescale 1ns/1ps
module lfc_lock_decode (
    input  wire logic              [7:0] lock_byte_i,
    input  wire logic                    debug_fuse_i,
    output lfc_pkg::lfc_prot_s           prot_o,
    output logic                   [1:0] lock_mode_o
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic logic is_unprog(input logic [7:0] b, input int pos);
        is_unprog = b[pos];
    endfunction

    logic low_free;
    logic high_free;

    always_comb begin
        low_free  = is_unprog(lock_byte_i, lfc_pkg::LOCK_LOW_BIT);
        high_free = is_unprog(lock_byte_i, lfc_pkg::LOCK_HIGH_BIT);
        // Undocumented high-only pattern reports mode 3 but keeps fuse_ok set, so fuse writes stay allowed
        if (low_free && high_free) begin
            lock_mode_o = lfc_pkg::LOCK_MODE_1;
        end else if (high_free) begin
            lock_mode_o = lfc_pkg::LOCK_MODE_2;
        end else begin
            lock_mode_o = lfc_pkg::LOCK_MODE_3;
        end
        prot_o.prog_ok   = low_free && high_free;
        prot_o.verify_ok = high_free;
        prot_o.fuse_ok   = low_free;
        // Debug fuse is programmed when low
        prot_o.debug_ok  = low_free && high_free && !debug_fuse_i;
    end

endmodule

// >>> lfc_prog_model.sv
// Programmer model driving the programming mode pins
`timescale 1ns/1ps
module lfc_prog_model (
    input  wire logic               clk_i,
    input  wire lfc_pkg::lfc_fuse_s live_i,
    output logic                    prog_mode_o,
    output logic                    hv_mode_o
);
    initial begin
        prog_mode_o = 1'b0;
        hv_mode_o   = 1'b0;
    end

    // Serial access is lost once the reset pin is given away
    task automatic enter(input logic hv);
        @(posedge clk_i);
        prog_mode_o <= 1'b1;
        hv_mode_o   <= hv | ~live_i.high[lfc_pkg::HIGH_RST_DIS_BIT];
        repeat (3) @(posedge clk_i);
    endtask

    task automatic leave();
        @(posedge clk_i);
        prog_mode_o <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// >>> tb.sv
// Self-checking testbench for the lock and fuse configuration store
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] SIG_A = 8'h4e; // Arbitrary identity value
    localparam logic [7:0] SIG_B = 8'h17; // Arbitrary identity value
    localparam logic [7:0] SIG_C = 8'hc9; // Arbitrary identity value
    localparam logic [7:0] CAL   = 8'h5b;
    logic               ref_clk_i = 1'b0;
    logic               nrst_i    = 1'b0;
    logic [3:0]         addr_i    = 4'h0;
    logic [7:0]         wdata_i   = 8'h00;
    logic               we_i      = 1'b0;
    logic               re_i      = 1'b0;
    logic               prog_mode_i;
    logic               hv_mode_i;
    logic [7:0]         rdata_o;
    logic [7:0]         osc_trim_o;
    lfc_pkg::lfc_prot_s prot_o;
    lfc_pkg::lfc_fuse_s fuse_live_o;
    logic [1:0]         lock_mode_o;
    logic               debug_flash_read_o;
    logic               flash_erase_o;
    logic               eeprom_erase_o;
    logic               int_rc_select_o;
    logic [7:0]         lfsr      = 8'h1a;
    int                 n_fail    = 0;
    int                 n_tests   = 0;
    int m_lock, m_ext, m_high, m_low, m_trim, m_live, m_prog, m_hv;

    always #4 ref_clk_i = ~ref_clk_i;

    lfc_store #(.SIG0(SIG_A), .SIG1(SIG_B), .SIG2(SIG_C), .CAL_BYTE(CAL)) i_dut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .prog_mode_i(prog_mode_i), .hv_mode_i(hv_mode_i),
        .rdata_o(rdata_o), .prot_o(prot_o), .lock_mode_o(lock_mode_o),
        .debug_flash_read_o(debug_flash_read_o), .flash_erase_o(flash_erase_o),
        .eeprom_erase_o(eeprom_erase_o), .fuse_live_o(fuse_live_o),
        .int_rc_select_o(int_rc_select_o), .osc_trim_o(osc_trim_o));

    lfc_prog_model i_prog (.clk_i(ref_clk_i), .live_i(fuse_live_o),
        .prog_mode_o(prog_mode_i), .hv_mode_o(hv_mode_i));

    // ------------------------------------------------------------------
    // Model and checks
    // ------------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic int mode_of();
        return (m_lock & 3) == 3 ? 1 : ((m_lock & 3) == 2 ? 2 : 3);
    endfunction

    function automatic logic [3:0] prot_of();
        logic dbg;
        dbg = (m_live[14] == 1'b0) && (mode_of() == 1);
        return {mode_of() == 1, m_lock[1], m_lock[0], dbg};
    endfunction

    function automatic int rd_exp(input logic [3:0] a);
        case (a)
            lfc_pkg::OFS_LOCK: return m_lock & 255;
            lfc_pkg::OFS_EXT:  return m_ext;
            lfc_pkg::OFS_HIGH: return m_high;
            lfc_pkg::OFS_LOW:  return m_low;
            lfc_pkg::OFS_SIG0: return SIG_A;
            lfc_pkg::OFS_SIG1: return SIG_B;
            lfc_pkg::OFS_SIG2: return SIG_C;
            lfc_pkg::OFS_CAL:  return CAL;
            lfc_pkg::OFS_CTRL: return m_hv * 2 + m_prog;
            lfc_pkg::OFS_STAT: return mode_of() * 16 + prot_of();
            lfc_pkg::OFS_TRIM: return m_trim;
            default:           return 0;
        endcase
    endfunction

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_outs();
        chk("lock_mode", lock_mode_o, mode_of());
        chk("prot", prot_o, prot_of());
        chk("fuse_live", fuse_live_o, m_live);
        chk("int_rc", int_rc_select_o, m_live[3:0] == 4'h2);
        chk("debug_read", debug_flash_read_o, m_live[14] == 1'b0);
        chk("trim", osc_trim_o, m_trim);
    endtask

    // ------------------------------------------------------------------
    // Bus and mode tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic ok;
        logic ers;
        ok  = m_prog && m_lock[0];
        ers = m_prog && a == lfc_pkg::OFS_CTRL && d[0];
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        @(posedge ref_clk_i);
        we_i    <= 1'b0;
        #1;
        case (a)
            lfc_pkg::OFS_LOCK: if (m_prog) m_lock = m_lock & (d | 8'hfc);
            lfc_pkg::OFS_EXT:  if (ok) m_ext = d | 8'hfe;
            lfc_pkg::OFS_HIGH: if (ok) m_high = m_hv ? d : (d & 8'hdf) | (m_high & 8'h20);
            lfc_pkg::OFS_LOW:  if (ok) m_low = d;
            lfc_pkg::OFS_TRIM: m_trim = d;
            default: ;
        endcase
        if (ers) m_lock = 255;
        chk("flash_erase", flash_erase_o, ers);
        chk("eeprom_erase", eeprom_erase_o, ers && m_high[3]);
        check_outs();
    endtask

    task automatic rd(input logic [3:0] a);
        int e;
        e = rd_exp(a);
        @(posedge ref_clk_i);
        addr_i <= a;
        re_i   <= 1'b1;
        @(posedge ref_clk_i);
        re_i   <= 1'b0;
        #1;
        chk("rdata", rdata_o, e);
        @(posedge ref_clk_i);
        #1;
        chk("rdata_idle", rdata_o, 0);
    endtask

    task automatic prog_on(input logic hv);
        i_prog.enter(hv);
        m_prog = 1;
        m_hv   = hv_mode_i;
        m_live = {m_ext[7:0], m_high[7:0], m_low[7:0]};
        #1;
        check_outs();
    endtask

    task automatic prog_off();
        i_prog.leave();
        m_prog = 0;
        m_live = {m_ext[7:0], m_high[7:0], m_low[7:0]};
        #1;
        check_outs();
    endtask

    task automatic do_reset();
        nrst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        m_lock = 255;
        m_ext  = 255;
        m_high = 8'hdf;
        m_low  = 8'h62;
        m_trim = CAL;
        m_prog = 0;
        m_hv   = hv_mode_i;
        m_live = {m_ext[7:0], m_high[7:0], m_low[7:0]};
        #1;
        check_outs();
    endtask

    task automatic done(input string name);
        $display("test %s ended, mismatches so far %0d", name, n_fail);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #(8 * 20000);
        n_fail++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        do_reset();
        for (int a = 0; a < 16; a++) begin
            rd(4'(a));
        end
        wr(lfc_pkg::OFS_LOW, 8'h00);
        rd(lfc_pkg::OFS_LOW);
        done("reset_map");
        // Fuses go in before any lock bit
        prog_on(1'b0);
        wr(lfc_pkg::OFS_HIGH, 8'hf7);
        wr(lfc_pkg::OFS_EXT, 8'h00);
        wr(lfc_pkg::OFS_LOW, 8'h64);
        rd(lfc_pkg::OFS_HIGH);
        rd(lfc_pkg::OFS_EXT);
        wr(lfc_pkg::OFS_CTRL, 8'h01);
        rd(lfc_pkg::OFS_LOW);
        prog_off();
        done("serial_fuses");
        prog_on(1'b1);
        wr(lfc_pkg::OFS_HIGH, 8'h3f);
        wr(lfc_pkg::OFS_LOW, 8'h62);
        prog_off();
        prog_on(1'b0);
        wr(lfc_pkg::OFS_CTRL, 8'h01);
        wr(lfc_pkg::OFS_LOCK, 8'hfe);
        wr(lfc_pkg::OFS_LOW, 8'h00);
        wr(lfc_pkg::OFS_LOCK, 8'hff);
        rd(lfc_pkg::OFS_STAT);
        for (int a = 0; a < 10; a++) begin
            rd(4'(a));
        end
        wr(lfc_pkg::OFS_LOCK, 8'hfd);
        for (int a = 4; a < 10; a++) begin
            rd(4'(a));
        end
        wr(lfc_pkg::OFS_CTRL, 8'h01);
        wr(lfc_pkg::OFS_LOCK, 8'hfd);
        wr(lfc_pkg::OFS_LOW, 8'h11);
        rd(lfc_pkg::OFS_STAT);
        prog_off();
        done("locks");
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(lfc_pkg::OFS_TRIM, lfsr);
            rd(lfc_pkg::OFS_TRIM);
            lfsr = lfsr_next(lfsr);
            rd(lfsr[3:0]);
        end
        done("random");
        wr(lfc_pkg::OFS_TRIM, 8'h00);
        do_reset();
        rd(lfc_pkg::OFS_CAL);
        rd(lfc_pkg::OFS_HIGH);
        done("second_reset");
        wrap_up();
    end
endmodule
